//--- test/volume_ramp_top_test.sv
// self-checking bench for the two-channel volume ramp block
`timescale 1ns/100ps
`default_nettype none
module volume_ramp_top_test;
  import volume_ramp_pkg::*;

  typedef struct packed {
    logic [7:0]          g1;
    logic [7:0]          g2;
    logic [SAMPLE_W-1:0] s1;
    logic [SAMPLE_W-1:0] s2;
    logic [SAMPLE_W-1:0] e1;
    logic [SAMPLE_W-1:0] e2;
  } row_t;

  logic                       clk_i;
  logic                       arst_n_i;
  logic        [7:0]          reg_addr_i;
  logic        [7:0]          reg_wdata_i;
  logic                       reg_we_i;
  logic                       reg_re_i;
  logic        [7:0]          reg_rdata_o;
  logic                       reg_rvalid_o;
  logic        [1:0]          link_mode_i;
  logic                       clock_error_i;
  logic                       supply_fail_i;
  logic                       word_select_frame_sync_i;
  logic signed [SAMPLE_W-1:0] first_sample_i;
  logic signed [SAMPLE_W-1:0] second_sample_i;
  logic                       out_valid_o;
  logic signed [SAMPLE_W-1:0] first_speaker_output_o;
  logic signed [SAMPLE_W-1:0] second_speaker_output_o;
  logic        [7:0]          first_applied_gain_o;
  logic        [7:0]          second_applied_gain_o;
  logic                       emerg_active_o;
  int                         err_total;
  int                         tests_run;
  int                         cycles;
  logic                       ov_seen;
  row_t                       rows [3];
  logic        [7:0]          link_exp [3][2];

  volume_ramp_top i_dut (
    .clk_i                   (clk_i),
    .arst_n_i                (arst_n_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_we_i                (reg_we_i),
    .reg_re_i                (reg_re_i),
    .reg_rdata_o             (reg_rdata_o),
    .reg_rvalid_o            (reg_rvalid_o),
    .link_mode_i             (link_mode_i),
    .clock_error_i           (clock_error_i),
    .supply_fail_i           (supply_fail_i),
    .word_select_frame_sync_i(word_select_frame_sync_i),
    .first_sample_i          (first_sample_i),
    .second_sample_i         (second_sample_i),
    .out_valid_o             (out_valid_o),
    .first_speaker_output_o  (first_speaker_output_o),
    .second_speaker_output_o (second_speaker_output_o),
    .first_applied_gain_o    (first_applied_gain_o),
    .second_applied_gain_o   (second_applied_gain_o),
    .emerg_active_o          (emerg_active_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk24(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk24

  // inputs move 1 ns after the rising edge
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  // strobes are dropped for one cycle so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_we_i    = 1'b1;
    tick();
    reg_we_i = 1'b0;
    tick();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_re_i   = 1'b1;
    tick();
    reg_re_i = 1'b0;
    chk8({7'h00, reg_rvalid_o}, 8'h01);
    chk8(reg_rdata_o, exp);
    tick();
    chk8({7'h00, reg_rvalid_o}, 8'h00);
  endtask : rd

  task automatic fs;
    word_select_frame_sync_i = 1'b1;
    tick();
    word_select_frame_sync_i = 1'b0;
    ov_seen = out_valid_o;
    tick();
  endtask : fs

  // frames until the first channel reaches tgt; each move is one clamped step, gap frames apart
  task automatic watch(input logic [7:0] tgt, input logic [7:0] stp, input int gap);
    logic [7:0] prev;
    logic [7:0] nxt;
    int         last;
    int         k;
    prev = first_applied_gain_o;
    last = -1;
    for (k = 0; k < 64 && prev !== tgt; k++) begin
      fs();
      if (first_applied_gain_o !== prev) begin
        if (tgt > prev) nxt = (tgt - prev > stp) ? prev + stp : tgt;
        else nxt = (prev - tgt > stp) ? prev - stp : tgt;
        chk8(first_applied_gain_o, nxt);
        if (last >= 0) chk8(8'(k - last), 8'(gap));
        last = k;
        prev = first_applied_gain_o;
      end
    end
    chk8(prev, tgt);
  endtask : watch

  initial begin
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    arst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    link_mode_i = LINK_INDEP;
    clock_error_i = 1'b0;
    supply_fail_i = 1'b0;
    word_select_frame_sync_i = 1'b0;
    first_sample_i = '0;
    second_sample_i = '0;
    rows[0] = '{8'h30, 8'hFF, 24'h123456, 24'h07FFFF, 24'h123456, 24'h000000};
    rows[1] = '{8'h24, 8'h3C, 24'h001000, 24'hFFF000, 24'h002000, 24'hFFF800};
    rows[2] = '{8'h00, 8'h48, 24'h001000, 24'h001000, 24'h010000, 24'h000400};
    link_exp = '{'{8'h20, 8'h60}, '{8'h60, 8'h60}, '{8'h20, 8'h20}};
    repeat (2) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    chk8(first_applied_gain_o, 8'h30);
    rd(ADDR_SECOND_GAIN, 8'h30);
    rd(ADDR_FIRST_GAIN, 8'h30);
    rd(ADDR_RAMP_CFG, 8'h22);
    rd(ADDR_EMERG_CFG, 8'h00);
    wr(8'h41, 8'hAA);
    rd(8'h41, 8'h00);
    wr(ADDR_SECOND_GAIN, 8'hA5);
    rd(ADDR_SECOND_GAIN, 8'hA5);
    wr(ADDR_EMERG_CFG, 8'hFF);
    rd(ADDR_EMERG_CFG, 8'hF0);
    wr(ADDR_EMERG_CFG, 8'h00);
    wr(ADDR_FIRST_GAIN, 8'h36);
    watch(8'h36, 8'h02, 1);
    wr(ADDR_RAMP_CFG, 8'hB4);
    wr(ADDR_FIRST_GAIN, 8'h45);
    watch(8'h45, 8'h08, 2);
    wr(ADDR_FIRST_GAIN, 8'h42);
    watch(8'h42, 8'h01, 4);
    // 2 dB steps, the one step code not used above; the last move is clamped
    wr(ADDR_RAMP_CFG, 8'h11);
    wr(ADDR_FIRST_GAIN, 8'h4F);
    watch(8'h4F, 8'h04, 1);
    // immediate rates from here on, so settings land without frames
    wr(ADDR_RAMP_CFG, 8'hCC);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_FIRST_GAIN, rows[i].g1);
      wr(ADDR_SECOND_GAIN, rows[i].g2);
      repeat (2) tick();
      first_sample_i = rows[i].s1;
      second_sample_i = rows[i].s2;
      fs();
      chk8({7'h00, ov_seen}, 8'h01);
      chk8({7'h00, out_valid_o}, 8'h00);
      chk24(first_speaker_output_o, rows[i].e1);
      chk24(second_speaker_output_o, rows[i].e2);
    end
    wr(ADDR_FIRST_GAIN, 8'h20);
    wr(ADDR_SECOND_GAIN, 8'h60);
    for (int m = 0; m < 3; m++) begin // the forbidden code 11 is never driven
      link_mode_i = 2'(m);
      repeat (3) tick();
      chk8(first_applied_gain_o, link_exp[m][0]);
      chk8(second_applied_gain_o, link_exp[m][1]);
    end
    link_mode_i = LINK_INDEP;
    repeat (3) tick();
    supply_fail_i = 1'b1;
    repeat (2) tick();
    chk8({7'h00, emerg_active_o}, 8'h01);
    watch(8'hFF, 8'h08, 1);
    supply_fail_i = 1'b0;
    repeat (3) tick();
    chk8({7'h00, emerg_active_o}, 8'h00);
    chk8(first_applied_gain_o, 8'h20);
    wr(ADDR_EMERG_CFG, 8'h70);
    wr(ADDR_FIRST_GAIN, 8'hF0);
    repeat (2) tick();
    clock_error_i = 1'b1;
    repeat (2) tick();
    watch(8'hFF, 8'h01, 2);
    clock_error_i = 1'b0;
    repeat (3) tick();
    chk8(first_applied_gain_o, 8'hF0);
    // emergency at the slowest rate with 1 dB steps
    wr(ADDR_EMERG_CFG, 8'hA0);
    clock_error_i = 1'b1;
    repeat (2) tick();
    watch(8'hFF, 8'h02, 4);
    clock_error_i = 1'b0;
    repeat (3) tick();
    chk8(first_applied_gain_o, 8'hF0);
    // reset again mid-run: everything must return to its power-up state
    arst_n_i = 1'b0;
    tick();
    chk8(first_applied_gain_o, 8'h30);
    arst_n_i = 1'b1;
    rd(ADDR_EMERG_CFG, 8'h00);
    rd(ADDR_RAMP_CFG, 8'h22);
    finish_test();
  end
endmodule : volume_ramp_top_test
`default_nettype wire

//--- verilog/gain_ramp_channel.sv
// one channel's gain ramp engine: walks the applied code toward its target
`timescale 1ns/100ps
`default_nettype none
module gain_ramp_channel
  import volume_ramp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       tick_i,
  input  wire logic       emerg_i,
  input  wire logic [7:0] target_i,
  input  wire logic [7:0] ramp_cfg_i,
  input  wire logic [7:0] emerg_cfg_i,
  output logic      [7:0] applied_o
);
  typedef struct packed {
    logic [7:0] applied;
    logic [1:0] cnt;
  } chan_state_t;

  chan_state_t q, d;
  logic [7:0]  tgt;
  logic [1:0]  rate;
  logic [1:0]  step;
  logic [7:0]  units;
  logic [1:0]  last;

  always_comb begin
    d = q;
    if (emerg_i) begin
      tgt  = GAIN_MUTE;
      rate = emerg_cfg_i[EM_RATE_LSB +: 2];
      step = emerg_cfg_i[EM_STEP_LSB +: 2];
    end else if (target_i < q.applied) begin
      tgt  = target_i;
      rate = ramp_cfg_i[UP_RATE_LSB +: 2];
      step = ramp_cfg_i[UP_STEP_LSB +: 2];
    end else begin
      tgt  = target_i;
      rate = ramp_cfg_i[DN_RATE_LSB +: 2];
      step = ramp_cfg_i[DN_STEP_LSB +: 2];
    end
    units = STEP_MAX_UNITS >> step;
    // 1, 2 or 4 sample periods per step
    last  = {rate[1], rate[1] | rate[0]};
    if (q.applied == tgt) begin
      d.cnt = 2'h0;
    end else if (rate == RATE_DIRECT) begin
      d.applied = tgt;
      d.cnt     = 2'h0;
    end else if (tick_i) begin
      // >= so a count left by a slower rate cannot stall a faster one
      if (q.cnt >= last) begin
        d.cnt = 2'h0;
        if (tgt > q.applied)
          d.applied = (tgt - q.applied <= units) ? tgt : q.applied + units;
        else
          d.applied = (q.applied - tgt <= units) ? tgt : q.applied - units;
      end else begin
        d.cnt = q.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{applied: RST_GAIN, cnt: 2'h0};
    end else begin
      q <= d;
    end
  end

  assign applied_o = q.applied;

  property p_emerg_down;
    @(posedge clk_i) disable iff (!arst_n_i)
    emerg_i |=> q.applied >= $past(q.applied);
  endproperty
  a_emerg_down: assert property (p_emerg_down) else $error("emergency ramp raised gain");

  property p_emerg_default;
    @(posedge clk_i) disable iff (!arst_n_i)
    (emerg_i && tick_i && emerg_cfg_i == RST_EMERG_CFG && q.applied < 8'hF7)
      |=> q.applied == $past(q.applied) + 8'h08;
  endproperty
  a_emerg_default: assert property (p_emerg_default) else $error("default emergency not 4 dB");

  property p_direct;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!emerg_i && ramp_cfg_i[UP_RATE_LSB +: 2] == RATE_DIRECT
      && ramp_cfg_i[DN_RATE_LSB +: 2] == RATE_DIRECT) |=> q.applied == $past(target_i);
  endproperty
  a_direct: assert property (p_direct) else $error("direct change not immediate");

  property p_step_bound;
    @(posedge clk_i) disable iff (!arst_n_i)
    (rate != RATE_DIRECT && q.applied < tgt)
      |=> 9'(q.applied) <= 9'($past(q.applied)) + 9'($past(units));
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("ramp step too large");

  property p_no_overshoot;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!emerg_i && q.applied <= target_i) ##1 $stable(target_i) && !emerg_i
      |-> q.applied <= target_i;
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("ramp overshot target");
endmodule : gain_ramp_channel
`default_nettype wire

//--- verilog/gain_scale.sv
// applies a half-dB gain code to one sample stream
`timescale 1ns/100ps
`default_nettype none
module gain_scale
  import volume_ramp_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       valid_i,
  input  wire logic signed [SAMPLE_W-1:0] sample_i,
  input  wire logic        [7:0]          code_i,
  output logic                            valid_o,
  output logic signed      [SAMPLE_W-1:0] sample_o
);
  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] sample;
  } scale_state_t;

  localparam logic signed [SAMPLE_W+8:0] SAT_HI = (33'sd1 <<< (SAMPLE_W-1)) - 33'sd1;
  localparam logic signed [SAMPLE_W+8:0] SAT_LO = -(33'sd1 <<< (SAMPLE_W-1));

  scale_state_t               q, d;
  logic        [3:0]          frac;
  logic        [4:0]          oct;
  logic signed [SAMPLE_W+8:0] prod;

  always_comb begin
    d       = q;
    frac    = 4'(code_i % 8'(CODES_PER_6DB));
    oct     = 5'(code_i / 8'(CODES_PER_6DB));
    // code 0 gives x16 (+24 dB); code 48 is exactly unity
    prod    = (sample_i * $signed({1'b0, MANT_TABLE[frac]})) >>> (UNITY_SHIFT + oct);
    d.valid = valid_i;
    if (valid_i) begin
      if (code_i == GAIN_MUTE)
        d.sample = '0;
      else if (prod > SAT_HI)
        d.sample = SAT_HI[SAMPLE_W-1:0];
      else if (prod < SAT_LO)
        d.sample = SAT_LO[SAMPLE_W-1:0];
      else
        d.sample = prod[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid_o  = q.valid;
  assign sample_o = q.sample;

  property p_mute_zero;
    @(posedge clk_i) disable iff (!arst_n_i)
    (valid_i && code_i == GAIN_MUTE) |=> valid_o && sample_o == '0;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("muted sample not zero");

  property p_unity;
    @(posedge clk_i) disable iff (!arst_n_i)
    (valid_i && code_i == RST_GAIN) |=> sample_o == $past(sample_i);
  endproperty
  a_unity: assert property (p_unity) else $error("0 dB code not unity");
endmodule : gain_scale
`default_nettype wire

//--- verilog/volume_ramp_pkg.sv
// shared constants for the two-channel volume ramp block
package volume_ramp_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SECOND_GAIN = 8'h3D;
  localparam logic [7:0] ADDR_FIRST_GAIN  = 8'h3E;
  localparam logic [7:0] ADDR_RAMP_CFG    = 8'h3F;
  localparam logic [7:0] ADDR_EMERG_CFG   = 8'h40;
  // reset values
  localparam logic [7:0] RST_GAIN         = 8'h30;
  localparam logic [7:0] RST_RAMP_CFG     = 8'h22;
  localparam logic [7:0] RST_EMERG_CFG    = 8'h00;
  localparam logic [7:0] EMERG_CFG_MASK   = 8'hF0;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;
  // gain codes
  localparam logic [7:0] GAIN_MUTE        = 8'hFF;
  localparam logic [7:0] GAIN_MAX_ATTEN   = 8'hFE;
  // field positions
  localparam int UP_RATE_LSB = 6;
  localparam int UP_STEP_LSB = 4;
  localparam int DN_RATE_LSB = 2;
  localparam int DN_STEP_LSB = 0;
  localparam int EM_RATE_LSB = 6;
  localparam int EM_STEP_LSB = 4;
  // field encodings
  localparam logic [1:0] RATE_DIRECT        = 2'h3;
  localparam logic [1:0] LINK_INDEP         = 2'h0;
  localparam logic [1:0] LINK_FOLLOW_SECOND = 2'h1;
  localparam logic [1:0] LINK_USE_FIRST     = 2'h2;
  // largest step in half-dB units (4 dB); step code n gives this >> n
  localparam logic [7:0] STEP_MAX_UNITS   = 8'h08;
  // datapath
  localparam int SAMPLE_W      = 24;
  localparam int CODES_PER_6DB = 12;
  localparam int UNITY_SHIFT   = 3;
  // 128 * 2^(-k/12): one 6 dB octave in half-dB steps
  localparam logic [11:0][7:0] MANT_TABLE = {
    8'h44, 8'h48, 8'h4C, 8'h51, 8'h55, 8'h5B,
    8'h60, 8'h66, 8'h6C, 8'h72, 8'h79, 8'h80};
endpackage : volume_ramp_pkg

//--- verilog/volume_ramp_top.sv
// two-channel gain stage with ramped volume, channel linking and emergency ramp-down
`timescale 1ns/100ps
`default_nettype none
// How it works
// - gain code 0 is +24 dB, each count is 0.5 dB less down to -103 dB at 254, 255 mutes, reset is 0 dB.
// - each of the two speaker outputs has its own 8-bit gain register.
// - link mode 00, the reset value, applies each channel's own gain code.
// - link mode 01 makes the first speaker output follow the second's gain.
// - link mode 10 uses the first speaker output's gain for both channels.
// - separate up and down rate fields step every 1, 2 or 4 sample periods, 11 changes at once.
// - separate up and down step fields give 4, 2, 1 or 0.5 dB per step, default 1 dB.
// - a serial clock error or supply failure starts an emergency ramp down.
// - the emergency ramp has its own rate and step fields, default 4 dB every sample period.
module volume_ramp_top
  import volume_ramp_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic        [7:0]          reg_addr_i,
  input  wire logic        [7:0]          reg_wdata_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  output logic             [7:0]          reg_rdata_o,
  output logic                            reg_rvalid_o,
  input  wire logic        [1:0]          link_mode_i,
  input  wire logic                       clock_error_i,
  input  wire logic                       supply_fail_i,
  input  wire logic                       word_select_frame_sync_i,
  input  wire logic signed [SAMPLE_W-1:0] first_sample_i,
  input  wire logic signed [SAMPLE_W-1:0] second_sample_i,
  output logic                            out_valid_o,
  output logic signed      [SAMPLE_W-1:0] first_speaker_output_o,
  output logic signed      [SAMPLE_W-1:0] second_speaker_output_o,
  output logic             [7:0]          first_applied_gain_o,
  output logic             [7:0]          second_applied_gain_o,
  output logic                            emerg_active_o
);
  typedef struct packed {
    logic [7:0] gain_first;
    logic [7:0] gain_second;
    logic [7:0] ramp_cfg;
    logic [7:0] emerg_cfg;
    logic [7:0] rdata;
    logic       rvalid;
    logic       emerg;
  } top_state_t;

  top_state_t q, d;
  logic [7:0] target_first;
  logic [7:0] target_second;
  logic [7:0] applied_first;
  logic [7:0] applied_second;
  logic       first_valid;
  logic       second_valid;
  logic       direct_both;

  // register port, registered emergency flag
  always_comb begin
    d        = q;
    d.rvalid = reg_re_i;
    // faults are levels; the ramp keeps pulling down while any is present
    d.emerg  = clock_error_i | supply_fail_i;
    if (reg_we_i) begin
      case (reg_addr_i)
        ADDR_SECOND_GAIN: d.gain_second = reg_wdata_i;
        ADDR_FIRST_GAIN:  d.gain_first  = reg_wdata_i;
        ADDR_RAMP_CFG:    d.ramp_cfg    = reg_wdata_i;
        ADDR_EMERG_CFG:   d.emerg_cfg   = reg_wdata_i & EMERG_CFG_MASK;
        default:          d.rdata       = q.rdata;
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        ADDR_SECOND_GAIN: d.rdata = q.gain_second;
        ADDR_FIRST_GAIN:  d.rdata = q.gain_first;
        ADDR_RAMP_CFG:    d.rdata = q.ramp_cfg;
        ADDR_EMERG_CFG:   d.rdata = q.emerg_cfg;
        default:          d.rdata = RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{gain_first:  RST_GAIN,
             gain_second: RST_GAIN,
             ramp_cfg:    RST_RAMP_CFG,
             emerg_cfg:   RST_EMERG_CFG,
             rdata:       RDATA_UNMAPPED,
             rvalid:      1'b0,
             emerg:       1'b0};
    end else begin
      q <= d;
    end
  end

  // channel linking
  always_comb begin
    case (link_mode_i)
      LINK_INDEP: begin
        target_first  = q.gain_first;
        target_second = q.gain_second;
      end
      LINK_FOLLOW_SECOND: begin
        target_first  = q.gain_second;
        target_second = q.gain_second;
      end
      LINK_USE_FIRST: begin
        target_first  = q.gain_first;
        target_second = q.gain_first;
      end
      default: begin
        // the forbidden encoding is treated as independent control
        target_first  = q.gain_first;
        target_second = q.gain_second;
      end
    endcase
  end

  gain_ramp_channel u_ramp_first (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .tick_i      (word_select_frame_sync_i),
    .emerg_i     (q.emerg),
    .target_i    (target_first),
    .ramp_cfg_i  (q.ramp_cfg),
    .emerg_cfg_i (q.emerg_cfg),
    .applied_o   (applied_first)
  );

  gain_ramp_channel u_ramp_second (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .tick_i      (word_select_frame_sync_i),
    .emerg_i     (q.emerg),
    .target_i    (target_second),
    .ramp_cfg_i  (q.ramp_cfg),
    .emerg_cfg_i (q.emerg_cfg),
    .applied_o   (applied_second)
  );

  // each sample is scaled by the gain applied before that frame's ramp step
  gain_scale u_scale_first (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .valid_i  (word_select_frame_sync_i),
    .sample_i (first_sample_i),
    .code_i   (applied_first),
    .valid_o  (first_valid),
    .sample_o (first_speaker_output_o)
  );

  gain_scale u_scale_second (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .valid_i  (word_select_frame_sync_i),
    .sample_i (second_sample_i),
    .code_i   (applied_second),
    .valid_o  (second_valid),
    .sample_o (second_speaker_output_o)
  );

  assign out_valid_o           = first_valid;
  assign reg_rdata_o           = q.rdata;
  assign reg_rvalid_o          = q.rvalid;
  assign first_applied_gain_o  = applied_first;
  assign second_applied_gain_o = applied_second;
  assign emerg_active_o        = q.emerg;

  // with both rates direct and no fault the applied code reaches the target one clock later,
  // so the link checks below look through the ramp engines, not only at the selector
  assign direct_both = !q.emerg
                       && q.ramp_cfg[UP_RATE_LSB +: 2] == RATE_DIRECT
                       && q.ramp_cfg[DN_RATE_LSB +: 2] == RATE_DIRECT;

  property p_link_indep;
    @(posedge clk_i) disable iff (!arst_n_i)
    (link_mode_i == LINK_INDEP && direct_both)
      |=> applied_first == $past(q.gain_first) && applied_second == $past(q.gain_second);
  endproperty
  a_link_indep: assert property (p_link_indep) else $error("independent mode mixes gains");

  property p_link_follow;
    @(posedge clk_i) disable iff (!arst_n_i)
    (link_mode_i == LINK_FOLLOW_SECOND && direct_both)
      |=> applied_first == $past(q.gain_second) && applied_second == $past(q.gain_second);
  endproperty
  a_link_follow: assert property (p_link_follow) else $error("first does not follow second");

  property p_link_first;
    @(posedge clk_i) disable iff (!arst_n_i)
    (link_mode_i == LINK_USE_FIRST && direct_both)
      |=> applied_first == $past(q.gain_first) && applied_second == $past(q.gain_first);
  endproperty
  a_link_first: assert property (p_link_first) else $error("first gain not used for both");

  property p_regs_separate;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_we_i && reg_addr_i == ADDR_SECOND_GAIN) |=>
      q.gain_second == $past(reg_wdata_i) && q.gain_first == $past(q.gain_first);
  endproperty
  a_regs_separate: assert property (p_regs_separate) else $error("gain registers not separate");

  property p_emerg_entry;
    @(posedge clk_i) disable iff (!arst_n_i)
    (supply_fail_i || clock_error_i) |=> q.emerg ##1 applied_first >= $past(applied_first);
  endproperty
  a_emerg_entry: assert property (p_emerg_entry) else $error("fault did not start ramp down");

  property p_rvalid_pulse;
    @(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> reg_rvalid_o == $past(reg_re_i);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid not one cycle");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
    !reg_re_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  property p_read_first;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_re_i && reg_addr_i == ADDR_FIRST_GAIN) |=> reg_rdata_o == $past(q.gain_first);
  endproperty
  a_read_first: assert property (p_read_first) else $error("first gain read wrong");

  property p_read_second;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_re_i && reg_addr_i == ADDR_SECOND_GAIN) |=> reg_rdata_o == $past(q.gain_second);
  endproperty
  a_read_second: assert property (p_read_second) else $error("second gain read wrong");

  property p_read_ramp;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_re_i && reg_addr_i == ADDR_RAMP_CFG) |=> reg_rdata_o == $past(q.ramp_cfg);
  endproperty
  a_read_ramp: assert property (p_read_ramp) else $error("ramp settings read wrong");

  property p_read_emerg;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_re_i && reg_addr_i == ADDR_EMERG_CFG) |=> reg_rdata_o == $past(q.emerg_cfg);
  endproperty
  a_read_emerg: assert property (p_read_emerg) else $error("emergency settings read wrong");

  // the four registers sit at consecutive offsets, so anything outside that span is unmapped
  property p_read_unmapped;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_re_i && (reg_addr_i < ADDR_SECOND_GAIN || reg_addr_i > ADDR_EMERG_CFG))
      |=> reg_rdata_o == RDATA_UNMAPPED;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_unmapped_write;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_we_i && (reg_addr_i < ADDR_SECOND_GAIN || reg_addr_i > ADDR_EMERG_CFG))
      |=> $stable(q.gain_first) && $stable(q.gain_second)
          && $stable(q.ramp_cfg) && $stable(q.emerg_cfg);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  property p_first_write;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_we_i && reg_addr_i == ADDR_FIRST_GAIN)
      |=> q.gain_first == $past(reg_wdata_i) && $stable(q.gain_second);
  endproperty
  a_first_write: assert property (p_first_write) else $error("first gain write wrong");

  property p_ramp_write;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_we_i && reg_addr_i == ADDR_RAMP_CFG) |=> q.ramp_cfg == $past(reg_wdata_i);
  endproperty
  a_ramp_write: assert property (p_ramp_write) else $error("ramp settings write lost");

  property p_emerg_write;
    @(posedge clk_i) disable iff (!arst_n_i)
    (reg_we_i && reg_addr_i == ADDR_EMERG_CFG)
      |=> q.emerg_cfg == ($past(reg_wdata_i) & EMERG_CFG_MASK);
  endproperty
  a_emerg_write: assert property (p_emerg_write) else $error("emergency write wrong");

  property p_emerg_mask;
    @(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |-> (q.emerg_cfg & ~EMERG_CFG_MASK) == 8'h00;
  endproperty
  a_emerg_mask: assert property (p_emerg_mask) else $error("unused emergency bits set");

  property p_emerg_level;
    @(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> emerg_active_o == $past(clock_error_i || supply_fail_i);
  endproperty
  a_emerg_level: assert property (p_emerg_level) else $error("emergency flag wrong");

  property p_out_valid;
    @(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> out_valid_o == $past(word_select_frame_sync_i);
  endproperty
  a_out_valid: assert property (p_out_valid) else $error("output valid not one frame");

  property p_mute_second;
    @(posedge clk_i) disable iff (!arst_n_i)
    (word_select_frame_sync_i && applied_second == GAIN_MUTE)
      |=> second_speaker_output_o == '0;
  endproperty
  a_mute_second: assert property (p_mute_second) else $error("muted second output not zero");
endmodule : volume_ramp_top
`default_nettype wire
